// ===== qpsel_top.sv
`timescale 1ns/1ps
`default_nettype none

module qpsel_top import qpsel_pkg::*; #(
	parameter int NUM_PORTS = 56,
	parameter int NUM_REASONS = 64
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [QPSEL_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [QPSEL_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// packet descriptor in
	input wire logic pkt_valid,
	input wire logic [$clog2(NUM_PORTS)-1:0] pkt_port,
	input wire logic [QPSEL_NSRC-1:0] cand_valid,
	input wire logic [QPSEL_NSRC-1:0][2:0] cand_pri,
	input wire logic tunnel_hit,
	input wire logic [1:0] tunnel_table_index,
	input wire logic pkt_rspan,
	input wire logic [11:0] pkt_vid,
	input wire logic pkt_drop_eligible_bit,
	input wire logic [2:0] pkt_tag_pri,
	input wire logic pkt_from_cpu,
	input wire logic [4:0] pkt_cpu_queue,
	input wire logic pkt_trap,
	input wire logic [$clog2(NUM_REASONS)-1:0] pkt_trap_reason,
	// descriptor out
	output logic out_valid,
	output logic [2:0] out_int_pri,
	output logic [2:0] out_port_queue,
	output logic [3:0] out_stack_queue,
	output logic out_stack_queue_invalid,
	output logic [4:0] out_cpu_queue,
	output logic [2:0] out_hdr_int_pri,
	output logic [$clog2(NUM_REASONS)-1:0] out_hdr_trap_reason
);

	// ------------------------------------------------------------
	// derived widths
	// ------------------------------------------------------------
	localparam int PW = $clog2(NUM_PORTS);
	localparam int RW = $clog2(NUM_REASONS);

	// ------------------------------------------------------------
	// configuration check
	// ------------------------------------------------------------
	// the address map leaves 64 words for ports and for reasons
	if (NUM_PORTS < 2 || NUM_PORTS > 64 || NUM_REASONS < 2 || NUM_REASONS > 64) begin : g_bad_cfg
		$error("qpsel_top: NUM_PORTS and NUM_REASONS must lie in 2..64");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		// configuration tables
		logic [NUM_PORTS-1:0][1:0] port_idx;
		logic [QPSEL_NTBL-1:0][63:0] sel_tbl;
		logic [11:0] rspan_inner_vid;
		logic [11:0] rspan_outer_vid;
		logic [QPSEL_NREM-1:0][2:0] inner_remap;
		logic [QPSEL_NREM-1:0][2:0] outer_remap;
		logic [QPSEL_NPRI-1:0][2:0] pri_queue;
		logic [QPSEL_NCPUQ-1:0][2:0] cpu_port_queue;
		logic [QPSEL_NCPUQ-1:0][3:0] cpu_stack_queue;
		logic [NUM_REASONS-1:0][4:0] reason_queue;
		// bus channel state
		logic aw_got;
		logic [QPSEL_ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		// descriptor result
		logic o_valid;
		logic [2:0] o_pri;
		logic [2:0] o_pq;
		logic [3:0] o_sq;
		logic o_sq_bad;
		logic [4:0] o_cq;
		logic [RW-1:0] o_rsn;
		// status, read only
		logic [15:0] pkt_cnt;
		logic [3:0] last_src;
		logic [1:0] last_tbl;
	} qpsel_st_t;

	qpsel_st_t st_ff;
	qpsel_st_t nxt_st;

	logic [1:0] tbl_sel;
	logic [63:0] cur_tbl;
	logic [QPSEL_NSRC-1:0][3:0] rank_wt;
	logic [2:0] pick_pri;
	logic [3:0] pick_rank;
	qpsel_dec_t wdec;
	qpsel_dec_t rdec;
	logic [31:0] wword;
	logic [2:0] pri_res;

	// ------------------------------------------------------------
	// register read view
	// ------------------------------------------------------------
	function automatic logic [31:0] rd_word(input qpsel_st_t s, input qpsel_dec_t d);
		logic [31:0] v;
		v = 32'h0;
		case (d.rg)
			QPSEL_RG_PORT: v = 32'(s.port_idx[d.idx]);
			QPSEL_RG_TLO: v = s.sel_tbl[d.idx[1:0]][31:0];
			QPSEL_RG_THI: v = s.sel_tbl[d.idx[1:0]][63:32];
			QPSEL_RG_RSPI: v = 32'(s.rspan_inner_vid);
			QPSEL_RG_RSPO: v = 32'(s.rspan_outer_vid);
			QPSEL_RG_STAT: v = (32'(s.pkt_cnt) << QPSEL_STAT_CNT_LSB)
				| (32'(s.last_tbl) << QPSEL_STAT_TBL_LSB)
				| (32'(s.last_src) << QPSEL_STAT_SRC_LSB) | 32'(s.o_pri);
			QPSEL_RG_IREM: v = 32'(s.inner_remap[d.idx[3:0]]);
			QPSEL_RG_OREM: v = 32'(s.outer_remap[d.idx[3:0]]);
			QPSEL_RG_P2Q: v = 32'(s.pri_queue[d.idx[2:0]]);
			QPSEL_RG_C2Q: v = 32'(s.cpu_port_queue[d.idx[4:0]]);
			QPSEL_RG_C2S: v = 32'(s.cpu_stack_queue[d.idx[4:0]]);
			QPSEL_RG_RSN: v = 32'(s.reason_queue[d.idx]);
			default: v = 32'h0;
		endcase
		return v;
	endfunction : rd_word

	// ------------------------------------------------------------
	// table lookup and weighted pick
	// ------------------------------------------------------------
	// a tunnel hit outranks the port's own table choice
	assign tbl_sel = tunnel_hit ? tunnel_table_index : st_ff.port_idx[pkt_port];
	assign cur_tbl = st_ff.sel_tbl[tbl_sel];

	// weights regathered in rank order, strongest first
	for (genvar g = 0; g < QPSEL_NSRC; g++) begin : g_rank
		assign rank_wt[g] = cur_tbl[QPSEL_SRC_LSB[g] +: 4];
	end

	// tie-break lives in the pick: lower rank index wins
	qpsel_pick u_pick (
		.weight(rank_wt),
		.cand_valid(cand_valid),
		.cand_pri(cand_pri),
		.sel_pri(pick_pri),
		.sel_rank(pick_rank)
	);

	// ------------------------------------------------------------
	// register access decode
	// ------------------------------------------------------------
	// write side decodes the held address, so aw and w may come apart
	assign wdec = qpsel_decode(st_ff.aw_addr, NUM_PORTS, NUM_REASONS);
	assign rdec = qpsel_decode(s_axi_araddr, NUM_PORTS, NUM_REASONS);
	assign wword = qpsel_merge(rd_word(st_ff, wdec), st_ff.w_data, st_ff.w_strb);

	// ------------------------------------------------------------
	// rspan bypass
	// ------------------------------------------------------------
	// rspan takes the tag priority through the remap pair chosen by vid;
	// a vid matching neither falls back to the weighted result
	always_comb begin
		pri_res = pick_pri;
		if (pkt_rspan) begin
			if (pkt_vid == st_ff.rspan_inner_vid) begin
				pri_res = st_ff.inner_remap[{pkt_drop_eligible_bit, pkt_tag_pri}];
			end else if (pkt_vid == st_ff.rspan_outer_vid) begin
				pri_res = st_ff.outer_remap[{pkt_drop_eligible_bit, pkt_tag_pri}];
			end
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		// write channel: address and data taken independently
		if (st_ff.awready && s_axi_awvalid) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (st_ff.wready && s_axi_wvalid) begin
			nxt_st.w_got = 1'b1;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end
		if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = (wdec.rg == QPSEL_RG_NONE) ? QPSEL_RESP_DECERR : QPSEL_RESP_OKAY;
			case (wdec.rg)
				QPSEL_RG_PORT: nxt_st.port_idx[wdec.idx] = wword[1:0];
				QPSEL_RG_TLO: nxt_st.sel_tbl[wdec.idx[1:0]][31:0] = wword;
				// reserved bits 39:36 and 63:48 are never stored
				QPSEL_RG_THI: nxt_st.sel_tbl[wdec.idx[1:0]][63:32] = wword & QPSEL_TBL_MASK[63:32];
				QPSEL_RG_RSPI: nxt_st.rspan_inner_vid = wword[11:0];
				QPSEL_RG_RSPO: nxt_st.rspan_outer_vid = wword[11:0];
				QPSEL_RG_IREM: nxt_st.inner_remap[wdec.idx[3:0]] = wword[2:0];
				QPSEL_RG_OREM: nxt_st.outer_remap[wdec.idx[3:0]] = wword[2:0];
				QPSEL_RG_P2Q: nxt_st.pri_queue[wdec.idx[2:0]] = wword[2:0];
				QPSEL_RG_C2Q: nxt_st.cpu_port_queue[wdec.idx[4:0]] = wword[2:0];
				QPSEL_RG_C2S: nxt_st.cpu_stack_queue[wdec.idx[4:0]] = wword[3:0];
				QPSEL_RG_RSN: nxt_st.reason_queue[wdec.idx] = wword[4:0];
				default: nxt_st.bvalid = 1'b1;
			endcase
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// one write in flight: no new beat until the response is taken
		nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

		// read channel
		if (st_ff.arready && s_axi_arvalid) begin
			nxt_st.arready = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd_word(st_ff, rdec);
			nxt_st.rresp = (rdec.rg == QPSEL_RG_NONE) ? QPSEL_RESP_DECERR : QPSEL_RESP_OKAY;
		end else if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
			nxt_st.arready = 1'b1;
		end

		// packet path: one result per descriptor, one cycle later
		nxt_st.o_valid = pkt_valid;
		if (pkt_valid) begin
			nxt_st.o_pri = pri_res;
			if (pkt_from_cpu) begin
				// local or stacked cpu traffic: port and stacking queues looked up in the cpu tables by pkt_cpu_queue
				nxt_st.o_pq = st_ff.cpu_port_queue[pkt_cpu_queue];
				nxt_st.o_sq = st_ff.cpu_stack_queue[pkt_cpu_queue];
			end else begin
				nxt_st.o_pq = st_ff.pri_queue[pri_res];
				nxt_st.o_sq = {1'b0, st_ff.pri_queue[pri_res]};
			end
			if (pkt_from_cpu) begin
				nxt_st.o_sq_bad = st_ff.cpu_stack_queue[pkt_cpu_queue] > QPSEL_SQ_MAX;
			end else begin
				nxt_st.o_sq_bad = 1'b0;
			end
			nxt_st.o_cq = pkt_trap ? st_ff.reason_queue[pkt_trap_reason]
				: pkt_cpu_queue;
			nxt_st.o_rsn = pkt_trap_reason;
			nxt_st.pkt_cnt = st_ff.pkt_cnt + 16'h0001;
			nxt_st.last_tbl = tbl_sel;
			nxt_st.last_src = pkt_rspan ? QPSEL_SRC_NONE : pick_rank;
		end

		// reset last, so it overrides every update above
		if (!aresetn) begin
			nxt_st = '0;
			nxt_st.awready = 1'b1;
			nxt_st.wready = 1'b1;
			nxt_st.arready = 1'b1;
			nxt_st.last_src = QPSEL_SRC_NONE;
		end
	end

	// one register stage holds all state
	always_ff @(posedge aclk) begin
		st_ff <= nxt_st;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready = st_ff.wready;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	assign out_valid = st_ff.o_valid;
	assign out_int_pri = st_ff.o_pri;
	assign out_port_queue = st_ff.o_pq;
	assign out_stack_queue = st_ff.o_sq;
	assign out_stack_queue_invalid = st_ff.o_sq_bad;
	assign out_cpu_queue = st_ff.o_cq;
	assign out_hdr_int_pri = st_ff.o_pri;
	assign out_hdr_trap_reason = st_ff.o_rsn;

endmodule : qpsel_top

`default_nettype wire

// ===== qpsel_pkg.sv
package qpsel_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam int QPSEL_ADDR_W = 12;
	localparam logic [11:0] QPSEL_BASE_PORT = 12'h000;
	localparam logic [11:0] QPSEL_BASE_TBL = 12'h100;
	localparam logic [11:0] QPSEL_RSPAN_IN = 12'h120;
	localparam logic [11:0] QPSEL_RSPAN_OUT = 12'h124;
	localparam logic [11:0] QPSEL_STATUS = 12'h128;
	localparam logic [11:0] QPSEL_BASE_IREM = 12'h140;
	localparam logic [11:0] QPSEL_BASE_OREM = 12'h180;
	localparam logic [11:0] QPSEL_BASE_P2Q = 12'h1c0;
	localparam logic [11:0] QPSEL_BASE_C2Q = 12'h200;
	localparam logic [11:0] QPSEL_BASE_C2S = 12'h280;
	localparam logic [11:0] QPSEL_BASE_RSN = 12'h300;

	// ------------------------------------------------------------
	// sizes and field layout
	// ------------------------------------------------------------
	localparam int QPSEL_NTBL = 4;
	localparam int QPSEL_NSRC = 11;
	localparam int QPSEL_NREM = 16;
	localparam int QPSEL_NPRI = 8;
	localparam int QPSEL_NCPUQ = 32;
	localparam logic [3:0] QPSEL_WT_MIN = 4'h1;
	localparam logic [3:0] QPSEL_WT_MAX = 4'hc;
	localparam logic [3:0] QPSEL_SQ_MAX = 4'hb;
	localparam logic [3:0] QPSEL_SRC_NONE = 4'hf;
	localparam logic [63:0] QPSEL_TBL_MASK = 64'h0000_ff0f_ffff_ffff;
	// weight field lsb per source, in tie-break rank order (rank 0 strongest):
	// acl, routing, mac vlan, protocol vlan, dscp, outer, inner, etag, tunnel, label, port
	localparam int QPSEL_SRC_LSB [0:QPSEL_NSRC-1] = '{4, 28, 20, 24, 8, 16, 12, 44, 32, 40, 0};
	localparam int QPSEL_STAT_CNT_LSB = 16;
	localparam int QPSEL_STAT_TBL_LSB = 8;
	localparam int QPSEL_STAT_SRC_LSB = 4;
	localparam logic [1:0] QPSEL_RESP_OKAY = 2'h0;
	localparam logic [1:0] QPSEL_RESP_DECERR = 2'h3;

	typedef enum {
		QPSEL_RG_NONE, QPSEL_RG_PORT, QPSEL_RG_TLO, QPSEL_RG_THI, QPSEL_RG_RSPI,
		QPSEL_RG_RSPO, QPSEL_RG_STAT, QPSEL_RG_IREM, QPSEL_RG_OREM, QPSEL_RG_P2Q,
		QPSEL_RG_C2Q, QPSEL_RG_C2S, QPSEL_RG_RSN
	} qpsel_region_t;

	typedef struct packed {
		qpsel_region_t rg;
		logic [5:0] idx;
	} qpsel_dec_t;

	// ------------------------------------------------------------
	// address decode, shared by read and write paths
	// ------------------------------------------------------------
	function automatic qpsel_dec_t qpsel_decode(input logic [11:0] a, input int nports,
		input int nrsn);
		qpsel_dec_t d;
		int w;
		d.rg = QPSEL_RG_NONE;
		d.idx = 6'h00;
		w = int'(a[11:2]);
		if (w < int'(QPSEL_BASE_PORT[11:2]) + nports) begin
			d.rg = QPSEL_RG_PORT;
			d.idx = 6'(w - int'(QPSEL_BASE_PORT[11:2]));
		end else if (w >= int'(QPSEL_BASE_TBL[11:2]) && w < int'(QPSEL_RSPAN_IN[11:2])) begin
			d.rg = w[0] ? QPSEL_RG_THI : QPSEL_RG_TLO;
			d.idx = 6'((w - int'(QPSEL_BASE_TBL[11:2])) >> 1);
		end else if (w == int'(QPSEL_RSPAN_IN[11:2])) begin
			d.rg = QPSEL_RG_RSPI;
		end else if (w == int'(QPSEL_RSPAN_OUT[11:2])) begin
			d.rg = QPSEL_RG_RSPO;
		end else if (w == int'(QPSEL_STATUS[11:2])) begin
			d.rg = QPSEL_RG_STAT;
		end else if (w >= int'(QPSEL_BASE_IREM[11:2]) && w < int'(QPSEL_BASE_OREM[11:2])) begin
			d.rg = QPSEL_RG_IREM;
			d.idx = 6'(w - int'(QPSEL_BASE_IREM[11:2]));
		end else if (w >= int'(QPSEL_BASE_OREM[11:2]) && w < int'(QPSEL_BASE_P2Q[11:2])) begin
			d.rg = QPSEL_RG_OREM;
			d.idx = 6'(w - int'(QPSEL_BASE_OREM[11:2]));
		end else if (w >= int'(QPSEL_BASE_P2Q[11:2])
			&& w < int'(QPSEL_BASE_P2Q[11:2]) + QPSEL_NPRI) begin
			d.rg = QPSEL_RG_P2Q;
			d.idx = 6'(w - int'(QPSEL_BASE_P2Q[11:2]));
		end else if (w >= int'(QPSEL_BASE_C2Q[11:2]) && w < int'(QPSEL_BASE_C2S[11:2])) begin
			d.rg = QPSEL_RG_C2Q;
			d.idx = 6'(w - int'(QPSEL_BASE_C2Q[11:2]));
		end else if (w >= int'(QPSEL_BASE_C2S[11:2]) && w < int'(QPSEL_BASE_RSN[11:2])) begin
			d.rg = QPSEL_RG_C2S;
			d.idx = 6'(w - int'(QPSEL_BASE_C2S[11:2]));
		end else if (w >= int'(QPSEL_BASE_RSN[11:2]) && w < int'(QPSEL_BASE_RSN[11:2]) + nrsn) begin
			d.rg = QPSEL_RG_RSN;
			d.idx = 6'(w - int'(QPSEL_BASE_RSN[11:2]));
		end
		return d;
	endfunction : qpsel_decode

	function automatic logic [31:0] qpsel_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return m;
	endfunction : qpsel_merge

endpackage : qpsel_pkg

// ===== qpsel_pick.sv
`timescale 1ns/1ps
`default_nettype none

module qpsel_pick import qpsel_pkg::*; (
	// candidates, rank order
	input wire logic [QPSEL_NSRC-1:0][3:0] weight,
	input wire logic [QPSEL_NSRC-1:0] cand_valid,
	input wire logic [QPSEL_NSRC-1:0][2:0] cand_pri,
	// result
	output logic [2:0] sel_pri,
	output logic [3:0] sel_rank
);

	logic [3:0] best_w;
	logic [3:0] eff_w;

	// ------------------------------------------------------------
	// weighted pick
	// ------------------------------------------------------------
	// walk from weakest rank up, so ties fall to the stronger rank
	always_comb begin
		best_w = 4'h0;
		eff_w = 4'h0;
		sel_pri = 3'h0;
		sel_rank = QPSEL_SRC_NONE;
		for (int i = QPSEL_NSRC - 1; i >= 0; i--) begin
			// absent candidate or out-of-range code counts as weight zero
			eff_w = (cand_valid[i] && weight[i] >= QPSEL_WT_MIN && weight[i] <= QPSEL_WT_MAX)
				? weight[i] : 4'h0;
			if (eff_w != 4'h0 && eff_w >= best_w) begin
				best_w = eff_w;
				sel_pri = cand_pri[i];
				sel_rank = 4'(i);
			end
		end
	end

endmodule : qpsel_pick

`default_nettype wire

// ===== qpsel_properties.sv
`timescale 1ns/1ps
`default_nettype none

module qpsel_properties import qpsel_pkg::*; #(
	parameter int NUM_PORTS = 56,
	parameter int NUM_REASONS = 64
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// packet in
	input wire logic pkt_valid,
	input wire logic [QPSEL_NSRC-1:0] cand_valid,
	input wire logic pkt_rspan,
	input wire logic pkt_from_cpu,
	input wire logic [4:0] pkt_cpu_queue,
	input wire logic pkt_trap,
	input wire logic [$clog2(NUM_REASONS)-1:0] pkt_trap_reason,
	// descriptor out
	input wire logic out_valid,
	input wire logic [2:0] out_int_pri,
	input wire logic [2:0] out_port_queue,
	input wire logic [3:0] out_stack_queue,
	input wire logic out_stack_queue_invalid,
	input wire logic [4:0] out_cpu_queue,
	input wire logic [2:0] out_hdr_int_pri,
	input wire logic [$clog2(NUM_REASONS)-1:0] out_hdr_trap_reason
);
	// ----
	// properties
	// ----
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_lat; pkt_valid |=> out_valid; endproperty
	a_lat: assert property (p_lat) else $error("no descriptor one cycle after packet");
	property p_one; !pkt_valid |=> !out_valid; endproperty
	a_one: assert property (p_one) else $error("descriptor without packet");
	property p_hold; !pkt_valid |=> $stable(out_int_pri) && $stable(out_port_queue); endproperty
	a_hold: assert property (p_hold) else $error("outputs moved between packets");
	property p_zero; pkt_valid && !pkt_rspan && cand_valid == '0 |=> out_int_pri == 3'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("no candidate but priority not zero");
	property p_hdr; out_valid |-> out_hdr_int_pri == out_int_pri; endproperty
	a_hdr: assert property (p_hdr) else $error("header priority differs");
	property p_rsn; pkt_valid |=> out_hdr_trap_reason == $past(pkt_trap_reason); endproperty
	a_rsn: assert property (p_rsn) else $error("header trap reason wrong");
	property p_cpuq; pkt_valid && !pkt_trap |=> out_cpu_queue == $past(pkt_cpu_queue);
	endproperty
	a_cpuq: assert property (p_cpuq) else $error("cpu queue not passed through");
	property p_sq;
		pkt_valid && !pkt_from_cpu |=> out_stack_queue == {1'b0, out_port_queue}
			&& !out_stack_queue_invalid;
	endproperty
	a_sq: assert property (p_sq) else $error("stacking queue differs from port queue");
	property p_inv; out_valid |-> out_stack_queue_invalid == (out_stack_queue > QPSEL_SQ_MAX);
	endproperty
	a_inv: assert property (p_inv) else $error("stacking invalid flag wrong");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("read data late");

	c_rspan: cover property (pkt_valid && pkt_rspan);
	c_cpu: cover property (pkt_valid && pkt_from_cpu);
	c_trap: cover property (pkt_valid && pkt_trap);
endmodule : qpsel_properties

bind qpsel_top qpsel_properties #(.NUM_PORTS(NUM_PORTS), .NUM_REASONS(NUM_REASONS))
	i_qpsel_properties (.*);

`default_nettype wire

// ===== qpsel_egress_sink.sv
`timescale 1ns/1ps
`default_nettype none

module qpsel_egress_sink import qpsel_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// descriptor from the selector
	input wire logic out_valid,
	input wire logic [3:0] out_stack_queue,
	input wire logic out_stack_queue_invalid,
	// tallies
	output logic [15:0] taken_cnt,
	output logic bad_stack
);
	// ----
	// queue manager side
	// ----
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			taken_cnt <= 16'h0000;
			bad_stack <= 1'b0;
		end else if (out_valid) begin
			taken_cnt <= taken_cnt + 16'h0001;
			// only twelve stacking queues, higher codes must arrive flagged
			if (out_stack_queue > QPSEL_SQ_MAX && !out_stack_queue_invalid) begin
				bad_stack <= 1'b1;
			end
		end
	end
endmodule : qpsel_egress_sink

`default_nettype wire

// ===== qpsel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module qpsel_tb_top import qpsel_pkg::*; ;
	// ----
	// signals
	// ----
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic pkt_valid, tunnel_hit, pkt_rspan, pkt_drop_eligible_bit, pkt_from_cpu, pkt_trap;
	logic out_valid, out_stack_queue_invalid, bad_stack;
	logic [11:0] s_axi_awaddr, s_axi_araddr, pkt_vid;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, tunnel_table_index;
	logic [2:0] s_axi_awprot, s_axi_arprot, pkt_tag_pri, out_int_pri, out_port_queue;
	logic [2:0] out_hdr_int_pri, sth, se;
	logic [3:0] s_axi_wstrb, out_stack_queue;
	logic [5:0] pkt_port, pkt_trap_reason, out_hdr_trap_reason, sp;
	logic [10:0] cand_valid, scv;
	logic [10:0][2:0] cand_pri;
	logic [4:0] pkt_cpu_queue, out_cpu_queue;
	logic [15:0] taken_cnt;
	int n_fail = 0, checks_done = 0, n_pkt = 0;
	// candidate of rank i carries priority i+2
	localparam logic [32:0] CPV = {3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h7, 3'h6, 3'h5, 3'h4,
		3'h3, 3'h2};
	logic [43:0] cfg [15] = '{{12'h014, 32'h1}, {12'h018, 32'h3}, {12'h108, 32'h7985_4aa3},
		{12'h10c, 32'hc707}, {12'h110, 32'hd}, {12'h118, 32'h1}, {12'h120, 32'h123},
		{12'h124, 32'h456}, {12'h174, 32'h6}, {12'h154, 32'h3}, {12'h18c, 32'h2},
		{12'h27c, 32'h5}, {12'h2fc, 32'hb}, {12'h2f8, 32'hc}, {12'h3fc, 32'h15}};
	logic [22:0] sel [8] = '{{6'h5, 11'h7ff, 3'h0, 3'h1}, {6'h5, 11'h77f, 3'h0, 3'h2},
		{6'h5, 11'h77e, 3'h0, 3'h6}, {6'h5, 11'h40c, 3'h0, 3'h5}, {6'h5, 11'h0, 3'h0, 3'h0},
		{6'h0, 11'h7ff, 3'h0, 3'h0}, {6'h0, 11'h7ff, 3'h5, 3'h1}, {6'h5, 11'h7ff, 3'h6, 3'h0}};
	logic [19:0] rsp [5] = '{{13'h1123, 4'hd, 3'h6}, {13'h1123, 4'h5, 3'h3},
		{13'h1456, 4'h3, 3'h2}, {13'h1777, 4'h3, 3'h1}, {13'h0123, 4'hd, 3'h1}};

	qpsel_top i_qpsel_top (.*);
	qpsel_egress_sink i_qpsel_egress_sink (.*);

	always #50 aclk = ~aclk;

	task automatic close_out();
		if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				`CHK("bresp", er, s_axi_bresp)
				break;
			end
		end
	endtask : wr

	task automatic rdr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				rd = s_axi_rdata;
				`CHK("rresp", er, s_axi_rresp)
				break;
			end
		end
		`CHK("rdata", ed, rd)
	endtask : rdr

	task automatic pkt(input logic [5:0] p, input logic [10:0] cv, input logic [32:0] cp,
		input logic [2:0] th, input logic [12:0] rs, input logic [3:0] dt, input logic [5:0] cq,
		input logic [6:0] tr);
		@(posedge aclk);
		pkt_valid <= 1'b1;
		pkt_port <= p;
		cand_valid <= cv;
		cand_pri <= cp;
		{tunnel_hit, tunnel_table_index} <= th;
		{pkt_rspan, pkt_vid} <= rs;
		{pkt_drop_eligible_bit, pkt_tag_pri} <= dt;
		{pkt_from_cpu, pkt_cpu_queue} <= cq;
		{pkt_trap, pkt_trap_reason} <= tr;
		@(posedge aclk);
		pkt_valid <= 1'b0;
		n_pkt++;
		#1 `CHK("out_valid", 1'b1, out_valid)
	endtask : pkt

	// ----
	// tests
	// ----
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
		s_axi_wstrb = 4'hf;
		{pkt_valid, pkt_port, cand_valid, cand_pri, tunnel_hit, tunnel_table_index} = '0;
		{pkt_rspan, pkt_vid, pkt_drop_eligible_bit, pkt_tag_pri} = '0;
		{pkt_from_cpu, pkt_cpu_queue, pkt_trap, pkt_trap_reason} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(QPSEL_BASE_TBL, 32'h0, 2'h0);
		rdr(QPSEL_STATUS, 32'h0000_00f0, 2'h0);
		wr(12'h01c, 32'hffff_ffff, 2'h0);
		rdr(12'h01c, 32'h3, 2'h0);
		wr(12'h104, 32'hffff_ffff, 2'h0);
		rdr(12'h104, 32'h0000_ff0f, 2'h0);
		wr(12'h104, 32'h0, 2'h0);
		s_axi_wstrb <= 4'h2;
		wr(12'h104, 32'hffff_ffff, 2'h0);
		rdr(12'h104, 32'h0000_ff00, 2'h0);
		s_axi_wstrb <= 4'hf;
		wr(12'h104, 32'h0, 2'h0);
		wr(12'h12c, 32'h1, QPSEL_RESP_DECERR);
		rdr(12'h12c, 32'h0, QPSEL_RESP_DECERR);
		wr(QPSEL_STATUS, 32'hffff_ffff, QPSEL_RESP_OKAY);
		for (int i = 0; i < 15; i++) wr(cfg[i][43:32], cfg[i][31:0], 2'h0);
		for (int p = 0; p < 8; p++) wr(QPSEL_BASE_P2Q + 12'(4 * p), 32'(7 - p), 2'h0);
		rdr(12'h10c, 32'h0000_c707, 2'h0);
		for (int i = 0; i < 8; i++) begin
			{sp, scv, sth, se} = sel[i];
			pkt(sp, scv, CPV, sth, 13'h0, 4'h0, 6'h0, 7'h0);
			`CHK("sel_pri", se, out_int_pri)
		end
		for (int i = 0; i < 5; i++) begin
			pkt(6'h5, 11'h7ff, CPV, 3'h0, rsp[i][19:7], rsp[i][6:3], 6'h0, 7'h0);
			`CHK("rspan_pri", rsp[i][2:0], out_int_pri)
		end
		for (int p = 0; p < 8; p++) begin
			pkt(6'h6, 11'h7ff, {3'(p), 30'h0}, 3'h0, 13'h0, 4'h0, 6'h0, 7'h0);
			`CHK("port_q", 3'(7 - p), out_port_queue)
			`CHK("stack_q", {1'b0, 3'(7 - p)}, out_stack_queue)
			`CHK("hdr_pri", 3'(p), out_hdr_int_pri)
		end
		pkt(6'h5, 11'h0, CPV, 3'h0, 13'h0, 4'h0, 6'h3f, 7'h0);
		`CHK("cpu_port_q", 3'h5, out_port_queue)
		`CHK("cpu_stack_q", 4'hb, out_stack_queue)
		`CHK("cpu_q", 5'h1f, out_cpu_queue)
		pkt(6'h5, 11'h0, CPV, 3'h0, 13'h0, 4'h0, 6'h3e, 7'h0);
		`CHK("stack_bad", 1'b1, out_stack_queue_invalid)
		pkt(6'h5, 11'h0, CPV, 3'h0, 13'h0, 4'h0, 6'h0, 7'h7f);
		`CHK("trap_q", 5'h15, out_cpu_queue)
		`CHK("hdr_rsn", 6'h3f, out_hdr_trap_reason)
		rdr(QPSEL_STATUS, {16'(n_pkt), 16'h01f0}, 2'h0);
		`CHK("taken", 16'(n_pkt), taken_cnt)
		`CHK("bad_stack", 1'b0, bad_stack)
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(QPSEL_STATUS, 32'h0000_00f0, 2'h0);
		rdr(12'h10c, 32'h0, 2'h0);
		close_out();
	end

	// cut a hang short, far beyond the few hundred cycles the tests need
	initial begin
		#2_000_000;
		n_fail++;
		close_out();
	end
endmodule : qpsel_tb_top

`default_nettype wire
